// file: hdl/gdp_bus_if.sv
`timescale 1ns/1ps
interface gdp_bus_if;
    import gdp_pkg::*;
    logic        wr_stb;
    logic [1:0]  addr;
    gdp_word_t   wdata;
    gdp_word_t   rdata;
    logic        cs_active;
    modport link (output wr_stb, output addr, output wdata, output cs_active, input rdata);
    modport regs (input wr_stb, input addr, input wdata, input cs_active, output rdata);
endinterface

// file: hdl/gdp_cfg.svh
`ifndef GDP_CFG_SVH
`define GDP_CFG_SVH

// register addresses on the serial link
`define GDP_ADDR_USER        2'h0
`define GDP_ADDR_SETUP       2'h1
`define GDP_ADDR_NVM         2'h2

// setup word: reserved bits above 16 read zero
`define GDP_SETUP_RESET      24'h00001C
`define GDP_SETUP_MASK       24'h01FFFF
`define GDP_B_OT_DIS         16
`define GDP_B_OT_PICK        15
`define GDP_B_TMR_BYP        14
`define GDP_B_PLAT_DIS       13
`define GDP_B_COLD_DIS       12
`define GDP_B_MASK_PLAT      11
`define GDP_F_MASK_HI        10
`define GDP_F_MASK_LO        7
`define GDP_B_ECC_SD         6
`define GDP_F_SUP_HI         5
`define GDP_F_SUP_LO         2
`define GDP_B_FIXREF         1
`define GDP_B_RATE           0

// status/command word
`define GDP_B_FDBL           5
`define GDP_B_FSNG           4
`define GDP_B_UDBL           3
`define GDP_B_USNG           2
`define GDP_B_GO             1
`define GDP_B_PREVIEW        0

// serial frame layout
`define GDP_ADDR_BITS        2
`define GDP_ZERO_BITS        5
`define GDP_HDR_BITS         8
`define GDP_FRAME_BITS       32

// timing
`define GDP_CLK_NS           20
`define GDP_PROG_MS          40
`define GDP_PROG_CYCLES      ((`GDP_PROG_MS * 1000000) / `GDP_CLK_NS)
`define GDP_OC_DETECT_CYCLES 100

// overcurrent mask windows in ns, code 0 to 15
`define GDP_MASK_NS_0        0
`define GDP_MASK_NS_1        360
`define GDP_MASK_NS_2        560
`define GDP_MASK_NS_3        770
`define GDP_MASK_NS_4        970
`define GDP_MASK_NS_5        1170
`define GDP_MASK_NS_6        1570
`define GDP_MASK_NS_7        1970
`define GDP_MASK_NS_8        2370
`define GDP_MASK_NS_9        2780
`define GDP_MASK_NS_10       3180
`define GDP_MASK_NS_11       3580
`define GDP_MASK_NS_12       3980
`define GDP_MASK_NS_13       4390
`define GDP_MASK_NS_14       4790
`define GDP_MASK_NS_15       5190

`endif

// file: hdl/gdp_pkg.sv
package gdp_pkg;
    typedef logic [23:0] gdp_word_t;
    typedef enum logic [1:0] {
        GDP_DRV_OFF,
        GDP_DRV_FULL,
        GDP_DRV_PLATEAU,
        GDP_DRV_SOFT
    } gdp_drive_e;
    typedef enum logic [2:0] {
        GDP_ST_IDLE,
        GDP_ST_MASK,
        GDP_ST_ON,
        GDP_ST_TWO_LEVEL,
        GDP_ST_SHUTDOWN
    } gdp_state_e;
endpackage

// file: hdl/gdp_regs.sv
`timescale 1ns/1ps
`include "gdp_cfg.svh"
module gdp_regs
    import gdp_pkg::*;
#(
    parameter int PROG_TIMEOUT_CYCLES = `GDP_PROG_CYCLES,
    parameter int OC_DETECT_CYCLES    = `GDP_OC_DETECT_CYCLES
)(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       spi_sclk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe_n,
    input  wire logic       gate_on_cmd,
    input  wire logic       overcurrent_detect,
    input  wire logic       first_temp_sense_hot,
    input  wire logic       second_temp_sense_hot,
    input  wire logic       first_temp_sense_cold,
    input  wire gdp_word_t  nvm_setup_word,
    input  wire logic       factory_bank_double_err,
    input  wire logic       factory_bank_single_err,
    input  wire logic       user_bank_double_err,
    input  wire logic       user_bank_single_err,
    input  wire logic       nvm_write_done,
    output logic            nvm_write_start,
    output gdp_word_t       nvm_write_word,
    output gdp_drive_e      gate_drive,
    output logic            fault,
    output logic            overheat_threshold_pick,
    output logic            fixed_trip_reference,
    output logic            temp_report_rate_pick,
    output logic [3:0]      secondary_supply_code
);
    localparam int NSYNC = 5;

    gdp_bus_if bus ();

    gdp_spi_slave u_link (
        .clk           (clk),
        .nrst          (nrst),
        .spi_sclk      (spi_sclk),
        .spi_cs_n      (spi_cs_n),
        .spi_mosi      (spi_mosi),
        .spi_miso      (spi_miso),
        .spi_miso_oe_n (spi_miso_oe_n),
        .bus           (bus.link)
    );

    // pin inputs pass two flops before any logic
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] pin_s1;
    logic [NSYNC-1:0] pin_s2;
    assign pin_raw = {first_temp_sense_cold, second_temp_sense_hot,
                      first_temp_sense_hot, overcurrent_detect, gate_on_cmd};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                end else begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                end
            end
        end
    endgenerate

    logic cmd_on, oc_hit, hot1, hot2, cold;
    assign cmd_on = pin_s2[0];
    assign oc_hit = pin_s2[1];
    assign hot1   = pin_s2[2];
    assign hot2   = pin_s2[3];
    assign cold   = pin_s2[4];

    // register state
    gdp_word_t setup_r;
    logic      load_pend_r;
    logic      preview_r;
    logic      go_r;
    logic      start_r;
    logic [3:0] ecc_r;
    logic [21:0] prog_cnt_r;
    logic      wr_setup, wr_ctrl, go_done;

    assign wr_setup = bus.wr_stb && bus.addr == `GDP_ADDR_SETUP;
    assign wr_ctrl  = bus.wr_stb && bus.addr == `GDP_ADDR_NVM;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            preview_r <= 1'b0;
        end else if (wr_ctrl) begin
            preview_r <= bus.wdata[`GDP_B_PREVIEW];
        end
    end

    // setup word: stored value loaded after reset and whenever preview drops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            setup_r     <= `GDP_SETUP_RESET;
            load_pend_r <= 1'b1;
        end else if (load_pend_r) begin
            setup_r     <= nvm_setup_word & `GDP_SETUP_MASK;
            load_pend_r <= 1'b0;
        end else if (wr_ctrl && preview_r && !bus.wdata[`GDP_B_PREVIEW]) begin
            setup_r <= nvm_setup_word & `GDP_SETUP_MASK;
        end else if (wr_setup) begin
            setup_r <= bus.wdata & `GDP_SETUP_MASK;
        end
    end

    // live setting: register only while previewing, else stored memory word
    gdp_word_t live;
    assign live = preview_r ? setup_r : (nvm_setup_word & `GDP_SETUP_MASK);

    // memory write handshake; done or timeout ends it, a new go wins
    assign go_done = nvm_write_done
                  || prog_cnt_r == 22'(PROG_TIMEOUT_CYCLES - 1);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            go_r       <= 1'b0;
            start_r    <= 1'b0;
            prog_cnt_r <= 22'h000000;
        end else begin
            start_r <= wr_ctrl && bus.wdata[`GDP_B_GO] && !go_r;
            if (wr_ctrl && bus.wdata[`GDP_B_GO]) begin
                go_r <= 1'b1;
                if (!go_r) begin
                    prog_cnt_r <= 22'h000000;
                end
            end else if (go_r && go_done) begin
                go_r <= 1'b0;
            end
            if (go_r && !go_done) begin
                prog_cnt_r <= prog_cnt_r + 22'h000001;
            end
        end
    end
    assign nvm_write_start = start_r;
    assign nvm_write_word  = setup_r;

    // memory check results follow the checker each cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ecc_r <= 4'h0;
        end else begin
            ecc_r <= {factory_bank_double_err, factory_bank_single_err,
                      user_bank_double_err, user_bank_single_err};
        end
    end

    gdp_word_t ctrl_word;
    always_comb begin
        ctrl_word = 24'h000000;
        ctrl_word[`GDP_B_FDBL:`GDP_B_USNG] = ecc_r;
        ctrl_word[`GDP_B_GO]      = go_r;
        ctrl_word[`GDP_B_PREVIEW] = preview_r;
    end

    always_comb begin
        unique case (bus.addr)
            `GDP_ADDR_SETUP: bus.rdata = setup_r;
            `GDP_ADDR_NVM:   bus.rdata = ctrl_word;
            default:         bus.rdata = 24'h000000;
        endcase
    end

    // static settings to the analog side
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overheat_threshold_pick <= 1'b0;
            fixed_trip_reference    <= 1'b0;
            temp_report_rate_pick   <= 1'b0;
            secondary_supply_code   <= 4'h7;
        end else begin
            overheat_threshold_pick <= live[`GDP_B_OT_PICK];
            fixed_trip_reference    <= live[`GDP_B_FIXREF];
            temp_report_rate_pick   <= live[`GDP_B_RATE];
            secondary_supply_code   <= live[`GDP_F_SUP_HI:`GDP_F_SUP_LO];
        end
    end

    // mask window in cycles, rounded up
    function automatic logic [8:0] mask_cycles(input logic [3:0] code);
        int ns;
        ns = 0;
        unique case (code)
            4'h0: ns = `GDP_MASK_NS_0;
            4'h1: ns = `GDP_MASK_NS_1;
            4'h2: ns = `GDP_MASK_NS_2;
            4'h3: ns = `GDP_MASK_NS_3;
            4'h4: ns = `GDP_MASK_NS_4;
            4'h5: ns = `GDP_MASK_NS_5;
            4'h6: ns = `GDP_MASK_NS_6;
            4'h7: ns = `GDP_MASK_NS_7;
            4'h8: ns = `GDP_MASK_NS_8;
            4'h9: ns = `GDP_MASK_NS_9;
            4'hA: ns = `GDP_MASK_NS_10;
            4'hB: ns = `GDP_MASK_NS_11;
            4'hC: ns = `GDP_MASK_NS_12;
            4'hD: ns = `GDP_MASK_NS_13;
            4'hE: ns = `GDP_MASK_NS_14;
            4'hF: ns = `GDP_MASK_NS_15;
        endcase
        return 9'((ns + `GDP_CLK_NS - 1) / `GDP_CLK_NS);
    endfunction

    // fault sources that shut the gate down outside the overcurrent path
    logic ot_fault, ecc_fault, hard_fault;
    assign ot_fault   = !live[`GDP_B_OT_DIS] && (hot1 || hot2);
    assign ecc_fault  = live[`GDP_B_ECC_SD] && (ecc_r != 4'h0);
    assign hard_fault = ot_fault || ecc_fault;

    gdp_state_e state_r;
    logic [8:0]  mask_cnt_r;
    logic [15:0] oc_cnt_r;
    logic        oc_expired;
    assign oc_expired = oc_cnt_r == 16'(OC_DETECT_CYCLES - 1);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r    <= GDP_ST_IDLE;
            mask_cnt_r <= 9'h000;
            oc_cnt_r   <= 16'h0000;
        end else if (bus.cs_active) begin
            state_r <= GDP_ST_IDLE;
        end else begin
            unique case (state_r)
                GDP_ST_IDLE: begin
                    if (hard_fault) begin
                        state_r <= GDP_ST_SHUTDOWN;
                    end else if (cmd_on) begin
                        mask_cnt_r <= mask_cycles(live[`GDP_F_MASK_HI:`GDP_F_MASK_LO]);
                        state_r    <= GDP_ST_MASK;
                    end
                end
                GDP_ST_MASK: begin
                    // overcurrent ignored while the mask runs
                    if (hard_fault) begin
                        state_r <= GDP_ST_SHUTDOWN;
                    end else if (!cmd_on) begin
                        state_r <= GDP_ST_IDLE;
                    end else if (mask_cnt_r <= 9'h001) begin
                        state_r <= GDP_ST_ON;
                    end else begin
                        mask_cnt_r <= mask_cnt_r - 9'h001;
                    end
                end
                GDP_ST_ON: begin
                    oc_cnt_r <= 16'h0000;
                    if (hard_fault) begin
                        state_r <= GDP_ST_SHUTDOWN;
                    end else if (!cmd_on) begin
                        state_r <= GDP_ST_IDLE;
                    end else if (oc_hit) begin
                        state_r <= live[`GDP_B_TMR_BYP] ? GDP_ST_SHUTDOWN
                                                        : GDP_ST_TWO_LEVEL;
                    end
                end
                GDP_ST_TWO_LEVEL: begin
                    if (hard_fault || oc_expired) begin
                        state_r <= GDP_ST_SHUTDOWN;
                    end else if (!oc_hit) begin
                        state_r <= cmd_on ? GDP_ST_ON : GDP_ST_IDLE;
                    end else begin
                        oc_cnt_r <= oc_cnt_r + 16'h0001;
                    end
                end
                GDP_ST_SHUTDOWN: begin
                    // latched until the command drops and no hot or memory fault remains, or a chip select forces idle; overcurrent is not checked
                    if (!cmd_on && !hard_fault) begin
                        state_r <= GDP_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // drive level per state
    logic cold_plateau;
    assign cold_plateau = cold && !live[`GDP_B_COLD_DIS];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gate_drive <= GDP_DRV_OFF;
            fault      <= 1'b0;
        end else begin
            fault <= state_r == GDP_ST_SHUTDOWN;
            unique case (state_r)
                GDP_ST_IDLE:      gate_drive <= GDP_DRV_OFF;
                GDP_ST_MASK:      gate_drive <= (oc_hit && live[`GDP_B_MASK_PLAT]) || cold_plateau
                                                ? GDP_DRV_PLATEAU : GDP_DRV_FULL;
                GDP_ST_ON:        gate_drive <= cold_plateau ? GDP_DRV_PLATEAU
                                                             : GDP_DRV_FULL;
                GDP_ST_TWO_LEVEL: gate_drive <= live[`GDP_B_PLAT_DIS] ? GDP_DRV_FULL
                                                                      : GDP_DRV_PLATEAU;
                GDP_ST_SHUTDOWN:  gate_drive <= GDP_DRV_SOFT;
            endcase
        end
    end
endmodule // gdp_regs

// file: hdl/gdp_spi_slave.sv
`timescale 1ns/1ps
`include "gdp_cfg.svh"
module gdp_spi_slave
    import gdp_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic spi_sclk,
    input  wire logic spi_cs_n,
    input  wire logic spi_mosi,
    output logic      spi_miso,
    output logic      spi_miso_oe_n,
    gdp_bus_if.link   bus
);
    logic      sclk_s1, sclk_s2, sclk_s3;
    logic      cs_n_s1, cs_n_s2;
    logic      mosi_s1, mosi_s2;
    logic      rise, fall, active;
    logic [5:0] bit_cnt_r;
    logic [7:0] hdr_r;
    gdp_word_t data_r;
    gdp_word_t tx_r;
    gdp_word_t wdata_r;
    logic [1:0] addr_r;
    logic      rw_r, zero_ok_r, miso_r, wr_stb_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            cs_n_s1 <= 1'b1;
            cs_n_s2 <= 1'b1;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            sclk_s1 <= spi_sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_n_s1 <= spi_cs_n;
            cs_n_s2 <= cs_n_s1;
            mosi_s1 <= spi_mosi;
            mosi_s2 <= mosi_s1;
        end
    end

    // idle-low clock, sample on falling edge, shift out on rising edge
    assign active = ~cs_n_s2;
    assign rise   = active & sclk_s2 & ~sclk_s3;
    assign fall   = active & ~sclk_s2 & sclk_s3;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_r <= 6'h00;
            hdr_r     <= 8'h00;
            data_r    <= 24'h000000;
            addr_r    <= 2'h0;
            rw_r      <= 1'b0;
            zero_ok_r <= 1'b0;
        end else if (!active) begin
            bit_cnt_r <= 6'h00;
        end else if (fall && bit_cnt_r < 6'(`GDP_FRAME_BITS)) begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
            if (bit_cnt_r < 6'(`GDP_HDR_BITS)) begin
                hdr_r <= {hdr_r[6:0], mosi_s2};
            end else begin
                data_r <= {data_r[22:0], mosi_s2};
            end
            if (bit_cnt_r == 6'(`GDP_ADDR_BITS - 1)) begin
                addr_r <= {hdr_r[0], mosi_s2};
            end
            if (bit_cnt_r == 6'(`GDP_HDR_BITS - 1)) begin
                rw_r      <= mosi_s2;
                zero_ok_r <= (hdr_r[`GDP_ZERO_BITS-1:0] == 5'h00);
            end
        end
    end

    // read data captured once the header is complete
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_r   <= 24'h000000;
            miso_r <= 1'b0;
        end else if (!active) begin
            miso_r <= 1'b0;
        end else if (fall && bit_cnt_r == 6'(`GDP_HDR_BITS - 1)) begin
            tx_r <= bus.rdata;
        end else if (rise && bit_cnt_r >= 6'(`GDP_HDR_BITS)
                     && bit_cnt_r < 6'(`GDP_FRAME_BITS)) begin
            miso_r <= tx_r[23];
            tx_r   <= {tx_r[22:0], 1'b0};
        end
    end

    // write strobe only for a full frame with clean filler bits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_stb_r <= 1'b0;
            wdata_r  <= 24'h000000;
        end else begin
            wr_stb_r <= fall && bit_cnt_r == 6'(`GDP_FRAME_BITS - 1) && rw_r && zero_ok_r;
            if (fall && bit_cnt_r == 6'(`GDP_FRAME_BITS - 1)) begin
                wdata_r <= {data_r[22:0], mosi_s2};
            end
        end
    end

    assign bus.wr_stb    = wr_stb_r;
    assign bus.addr      = addr_r;
    assign bus.wdata     = wdata_r;
    assign bus.cs_active = active;
    assign spi_miso      = miso_r;
    assign spi_miso_oe_n = ~active;
endmodule // gdp_spi_slave

// file: testbench/gdp_host_model.sv
`timescale 1ns/1ps
module gdp_host_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // sclk idles low and stands still between frames; 8 clk per bit
    task automatic xfer(input logic [1:0] a, input logic wr, input logic [23:0] d,
                        input logic [4:0] zf, output logic [23:0] q);
        logic [31:0] f;
        f = {a, zf, wr, d};
        q = 24'h000000;
        @(posedge clk) cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 31; i >= 0; i--) begin
            sclk <= 1'b1;
            mosi <= f[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            if (i < 24) q[i] = miso;
            repeat (4) @(posedge clk);
        end
        // long tail so the write lands before deselect
        repeat (12) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~f[0];
        repeat (8) @(posedge clk);
    endtask
endmodule // gdp_host_model

// file: testbench/gdp_regs_sva.sv
`timescale 1ns/1ps
module gdp_regs_sva
    import gdp_pkg::*;
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       spi_cs_n,
    input wire logic       spi_miso,
    input wire logic       spi_miso_oe_n,
    input wire logic       gate_on_cmd,
    input wire logic       nvm_write_start,
    input wire gdp_drive_e gate_drive,
    input wire logic       fault,
    input wire logic       overheat_threshold_pick,
    input wire logic       fixed_trip_reference,
    input wire logic       temp_report_rate_pick,
    input wire logic [3:0] secondary_supply_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_cs_gate_off;
        !spi_cs_n [*6] |-> gate_drive == GDP_DRV_OFF;
    endproperty
    a_cs_gate_off: assert property (p_cs_gate_off) else $error("gate on while selected");
    property p_miso_idle;
        spi_cs_n [*4] |-> spi_miso_oe_n && !spi_miso;
    endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("miso driven while idle");
    property p_miso_drive;
        !spi_cs_n [*4] |-> !spi_miso_oe_n;
    endproperty
    a_miso_drive: assert property (p_miso_drive) else $error("miso not driven");
    property p_start_pulse;
        nvm_write_start |=> !nvm_write_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("write start too long");
    property p_fault_soft;
        $rose(fault) |-> ##[0:2] gate_drive == GDP_DRV_SOFT;
    endproperty
    a_fault_soft: assert property (p_fault_soft) else $error("fault without soft off");
    property p_mask_start;
        $rose(gate_on_cmd) |=> gate_drive != GDP_DRV_FULL;
    endproperty
    a_mask_start: assert property (p_mask_start) else $error("full drive too early");
    property p_settings_hold;
        spi_cs_n [*8] |-> $stable({overheat_threshold_pick, fixed_trip_reference,
                                   temp_report_rate_pick, secondary_supply_code});
    endproperty
    a_settings_hold: assert property (p_settings_hold) else $error("settings moved");
    property p_idle_off;
        (!gate_on_cmd && !fault) [*6] |-> gate_drive == GDP_DRV_OFF;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("gate on without command");
endmodule // gdp_regs_sva

bind gdp_regs gdp_regs_sva u_sva (
    .clk(clk), .nrst(nrst), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .gate_on_cmd(gate_on_cmd),
    .nvm_write_start(nvm_write_start), .gate_drive(gate_drive), .fault(fault),
    .overheat_threshold_pick(overheat_threshold_pick),
    .fixed_trip_reference(fixed_trip_reference),
    .temp_report_rate_pick(temp_report_rate_pick),
    .secondary_supply_code(secondary_supply_code));

// file: testbench/test_gdp_regs.sv
`timescale 1ns/1ps
module test_gdp_regs;
    import gdp_pkg::*;
    localparam gdp_word_t W0 = 24'h00809D;
    logic       clk, nrst, miso, oe_n, cmd, oc, hot1, hot2, cold, done, start;
    logic       sclk, cs_n, mosi, otp, fixr, rate;
    logic [3:0] errs, sup;
    gdp_word_t  nvw, q;
    gdp_drive_e drv;
    logic       flt;
    int         err_total, comparisons, starts;

    gdp_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    gdp_regs #(.PROG_TIMEOUT_CYCLES(2000), .OC_DETECT_CYCLES(10)) DUT (
        .clk(clk), .nrst(nrst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe_n(oe_n), .gate_on_cmd(cmd),
        .overcurrent_detect(oc), .first_temp_sense_hot(hot1),
        .second_temp_sense_hot(hot2), .first_temp_sense_cold(cold),
        .nvm_setup_word(W0), .factory_bank_double_err(errs[3]),
        .factory_bank_single_err(errs[2]), .user_bank_double_err(errs[1]),
        .user_bank_single_err(errs[0]), .nvm_write_done(done), .nvm_write_start(start),
        .nvm_write_word(nvw), .gate_drive(drv), .fault(flt),
        .overheat_threshold_pick(otp), .fixed_trip_reference(fixr),
        .temp_report_rate_pick(rate), .secondary_supply_code(sup));

    initial clk = 1'b0;
    always #10 clk = ~clk;
    always @(posedge clk) if (start) starts++;

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input gdp_word_t d);
        host.xfer(a, 1'b1, d, 5'h00, q);
    endtask
    task automatic rchk(input logic [1:0] a, input gdp_word_t e);
        host.xfer(a, 1'b0, 24'h000000, 5'h00, q);
        check(q, e);
    endtask
    // settings outputs as {pick, fixed, rate, supply}
    task automatic outs(input gdp_word_t w);
        check({otp, fixr, rate, sup}, {w[15], w[1], w[0], w[5:2]});
    endtask
    // cause bits: overcurrent, hot sense 1, hot sense 2, user bank single error
    task automatic fault_case(input gdp_word_t w, input logic [3:0] c, input logic ef);
        int n;
        wr(2'h1, w);
        wr(2'h2, 24'h000001);
        @(posedge clk) cmd <= 1'b1;
        n = 0;
        while (drv !== GDP_DRV_FULL && n < 40) begin
            @(posedge clk);
            n++;
        end
        check({22'h0, drv}, {22'h0, GDP_DRV_FULL});
        {oc, hot1, hot2, errs[0]} <= c;
        repeat (30) @(posedge clk);
        check({23'h0, flt}, {23'h0, ef});
        check({22'h0, drv}, {22'h0, ef ? GDP_DRV_SOFT : GDP_DRV_FULL});
        {oc, hot1, hot2, errs[0], cmd} <= 5'h00;
        repeat (20) @(posedge clk);
        check({22'h0, drv}, {22'h0, GDP_DRV_OFF});
        $display("fault case %h %b done", w, c);
    endtask

    initial begin
        {nrst, cmd, oc, hot1, hot2, cold, done, errs} = '0;
        err_total = 0;
        comparisons = 0;
        starts = 0;
        repeat (16) @(posedge clk);
        check({20'h0, sup}, 24'h000007);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        outs(W0);
        rchk(2'h1, W0);
        errs <= 4'b1010;
        rchk(2'h2, 24'h000028);
        rchk(2'h3, 24'h000000);
        host.xfer(2'h1, 1'b1, 24'h000FFF, 5'h04, q);
        rchk(2'h1, W0);
        $display("register read test done");
        wr(2'h1, 24'h000033);
        outs(W0);
        rchk(2'h1, 24'h000033);
        wr(2'h2, 24'h000002);
        check(starts, 1);
        check(nvw, 24'h000033);
        rchk(2'h2, 24'h00002A);
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        for (int i = 0; i < 8 && q[1] !== 1'b0; i++)
            host.xfer(2'h2, 1'b0, 24'h000000, 5'h00, q);
        check(q, 24'h000028);
        $display("program test done");
        wr(2'h2, 24'h000001);
        outs(24'h000033);
        wr(2'h2, 24'h000000);
        outs(W0);
        rchk(2'h1, W0);
        $display("preview test done");
        errs <= 4'b0000;
        fault_case(24'h00105C, 4'b1000, 1'b1);
        fault_case(24'h00505C, 4'b1000, 1'b1);
        fault_case(24'h00105C, 4'b0100, 1'b1);
        fault_case(24'h01105C, 4'b0010, 1'b0);
        fault_case(24'h00105C, 4'b0001, 1'b1);
        fault_case(24'h00101C, 4'b0001, 1'b0);
        wr(2'h1, 24'h00005C);
        @(posedge clk) {cmd, cold} <= 2'b11;
        repeat (10) @(posedge clk);
        check({22'h0, drv}, {22'h0, GDP_DRV_PLATEAU});
        {cmd, cold} <= 2'b00;
        // longest mask, 5.19 us is 260 cycles: overcurrent ignored until then
        wr(2'h1, 24'h001FDC);
        @(posedge clk) {cmd, oc} <= 2'b11;
        repeat (240) @(posedge clk);
        check({23'h0, flt}, 24'h000000);
        check({22'h0, drv}, {22'h0, GDP_DRV_PLATEAU});
        repeat (60) @(posedge clk);
        check({23'h0, flt}, 24'h000001);
        {cmd, oc} <= 2'b00;
        repeat (10) @(posedge clk);
        $display("cold and mask test done");
        stop_test();
    end

    initial begin
        #400_000;
        err_total++;
        stop_test();
    end
endmodule // test_gdp_regs
